// [design/qim_pkg.sv]
// package: shared constants and types of the quad 8x8 multiplier
package qim_pkg;

    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int unsigned CHANNELS  = 4;
    localparam int unsigned OPND_W    = 8;
    localparam int unsigned PROD_W    = 16;
    localparam int unsigned MAG_W     = 7;

    typedef logic [OPND_W-1:0]                 qim_opnd_t;
    typedef logic [PROD_W-1:0]                 qim_prod_t;
    typedef logic [CHANNELS-1:0][OPND_W-1:0]   qim_quad_opnd_t;
    typedef logic [CHANNELS-1:0][PROD_W-1:0]   qim_quad_prod_t;
    typedef logic [CHANNELS-1:0]               qim_chan_bits_t;

    // ---------------------------------------------------------------
    // operand encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        QIM_ENC_UNSIGNED = 2'h0,
        QIM_ENC_TWOS     = 2'h1,
        QIM_ENC_SIGNMAG  = 2'h2
    } qim_enc_t;

    // per-channel stage switches or styles, one group of four per stage
    typedef struct packed {
        qim_chan_bits_t product;
        qim_chan_bits_t operand_y;
        qim_chan_bits_t operand_x;
    } qim_stage_set_t;

    // ---------------------------------------------------------------
    // register map (byte addresses) and fields
    // ---------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_STAGE_ON    = 8'h04;
    localparam logic [7:0]  ADDR_CLEAR_STYLE = 8'h08;
    localparam logic [7:0]  ADDR_PRODUCT_LO  = 8'h0c;
    localparam logic [7:0]  ADDR_PRODUCT_HI  = 8'h10;
    localparam int unsigned ADDR_W           = 8;

    localparam int unsigned CTRL_FALL_BIT    = 0;
    localparam int unsigned CTRL_ENC_LSB     = 1;
    localparam int unsigned CTRL_W           = 3;
    localparam int unsigned STAGE_SET_W      = 12;

    localparam logic [CTRL_W-1:0]      CTRL_RESET        = 3'h0;
    localparam logic [STAGE_SET_W-1:0] STAGE_ON_RESET    = 12'h000;
    localparam logic [STAGE_SET_W-1:0] CLEAR_STYLE_RESET = 12'h000;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

endpackage

// [design/qim_stage.sv]
// one optional pipeline register with its own enable, clear and clear style
`timescale 1ns/100ps
module qim_stage #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             stage_clk,
    input  wire logic             present,
    input  wire logic             clear_async,
    input  wire logic             clear_low,
    input  wire logic             capture,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    import qim_pkg::*;

    logic [WIDTH-1:0] stage_q;
    logic             arst_n;

    // only an unclocked, present stage sees the reset without an edge
    assign arst_n = ~(present & clear_async & ~clear_low);

    // clocked clear wins over capture; enable low holds contents
    always_ff @(posedge stage_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= '0;
        end else if (!clear_low) begin
            stage_q <= '0;
        end else if (capture) begin
            stage_q <= d;
        end
    end

    // absent stage passes data straight through, adding no latency
    assign q = present ? stage_q : d;
endmodule

// [design/qim_mult_unit.sv]
// one 8x8 product in the selected operand encoding
`timescale 1ns/100ps
module qim_mult_unit (
    input  wire logic         [1:0]  encoding,
    input  wire qim_pkg::qim_opnd_t  x,
    input  wire qim_pkg::qim_opnd_t  y,
    output qim_pkg::qim_prod_t       product
);
    import qim_pkg::*;

    logic [PROD_W-1:0] prod_unsigned;
    logic [PROD_W-1:0] prod_twos;
    logic [PROD_W-1:0] prod_signmag;
    logic [2*MAG_W-1:0] mag_prod;
    logic              mag_sign;

    // the three interpretations are computed side by side, then selected
    assign prod_unsigned = x * y;
    assign prod_twos     = PROD_W'($signed(x) * $signed(y));
    assign mag_prod      = x[MAG_W-1:0] * y[MAG_W-1:0];
    assign mag_sign      = x[OPND_W-1] ^ y[OPND_W-1];
    assign prod_signmag  = {mag_sign, 1'b0, mag_prod};

    // an unused encoding code falls back to unsigned
    always_comb begin
        case (encoding)
            QIM_ENC_TWOS:    product = prod_twos;
            QIM_ENC_SIGNMAG: product = prod_signmag;
            default:         product = prod_unsigned;
        endcase
    end
endmodule

// [design/qim_quad_mult.sv]
// top: four independent 8x8 multiply channels with an ahb-lite config port
//
// Summary of operation
// - four channels multiply their own 8-bit x and y operands in parallel
// - each stage level switched on adds one cycle of latency; x and y stages sit in parallel
// - one edge setting picks rising or falling clock edge; rising by default
// - one encoding for all inputs: 0 unsigned, 1 two's complement, 2 sign-magnitude
// - each channel has x, y and product stage switches, all off by default
// - clocked clear style zeroes a stage on an active edge while reset is low
// - unclocked clear style zeroes a stage at once when reset goes low
// - four active-low channel resets load zero into their stages
// - an operand stage captures only while its enable is high, else holds
// - a product stage captures only while its enable is high, else holds
// - apart from an unclocked clear, stages update only on the selected edge of the one clock
// - each channel drives its own 16-bit product bus
`timescale 1ns/100ps
module qim_quad_mult (
    input  wire logic                    clock,
    input  wire logic                    resetn,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic      [31:0]             hrdata,
    // fabric side
    input  wire qim_pkg::qim_quad_opnd_t multiplicand_x,
    input  wire qim_pkg::qim_quad_opnd_t multiplicand_y,
    input  wire qim_pkg::qim_chan_bits_t chan_clear_low,
    input  wire qim_pkg::qim_chan_bits_t operand_x_stage_hold_n,
    input  wire qim_pkg::qim_chan_bits_t operand_y_stage_hold_n,
    input  wire qim_pkg::qim_chan_bits_t product_stage_hold_n,
    output qim_pkg::qim_quad_prod_t      chan_product
);
    import qim_pkg::*;

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    logic [CTRL_W-1:0]      ctrl_q;
    logic [CTRL_W-1:0]      ctrl_d;
    logic [STAGE_SET_W-1:0] stage_on_q;
    logic [STAGE_SET_W-1:0] stage_on_d;
    logic [STAGE_SET_W-1:0] clear_style_q;
    logic [STAGE_SET_W-1:0] clear_style_d;

    // ---------------------------------------------------------------
    // ahb-lite address and data phase
    // ---------------------------------------------------------------
    logic              wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [31:0]       hrdata_d;
    logic              addr_take;
    logic              rd_take;
    logic              wr_take;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_word;
    logic [31:0]       rd_fwd;
    logic              fwd_hit;

    // an address phase counts only when selected, nonseq and bus ready
    assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign rd_take   = addr_take & ~hwrite;
    assign wr_take   = addr_take & hwrite;
    assign rd_addr   = haddr[ADDR_W-1:0];

    // ---------------------------------------------------------------
    // datapath wires
    // ---------------------------------------------------------------
    qim_stage_set_t    on_set;
    qim_stage_set_t    async_set;
    qim_quad_opnd_t    x_staged;
    qim_quad_opnd_t    y_staged;
    qim_quad_prod_t    raw_product;
    logic              stage_clk;
    logic [1:0]        encoding;

    assign on_set    = stage_on_q;
    assign async_set = clear_style_q;
    assign encoding  = ctrl_q[CTRL_ENC_LSB +: 2];

    // the edge choice inverts the stage clock; changing it mid-run gives
    // one spurious edge, so software should set it with the stages idle
    assign stage_clk = clock ^ ctrl_q[CTRL_FALL_BIT];

    // ---------------------------------------------------------------
    // register read mux
    // ---------------------------------------------------------------
    function automatic logic [31:0] read_mux(
        input logic [ADDR_W-1:0]      a,
        input logic [CTRL_W-1:0]      c,
        input logic [STAGE_SET_W-1:0] s,
        input logic [STAGE_SET_W-1:0] k,
        input qim_quad_prod_t         p
    );
        logic [31:0] w;
        w = '0;
        case (a)
            ADDR_CTRL:        w = {29'h0, c};
            ADDR_STAGE_ON:    w = {20'h0, s};
            ADDR_CLEAR_STYLE: w = {20'h0, k};
            ADDR_PRODUCT_LO:  w = {p[1], p[0]};
            ADDR_PRODUCT_HI:  w = {p[3], p[2]};
            default:          w = '0;
        endcase
        return w;
    endfunction

    // a read right behind a write to the same word sees the new value
    assign fwd_hit = wr_pend_q & (wr_addr_q == rd_addr);
    assign rd_word = read_mux(rd_addr, ctrl_q, stage_on_q, clear_style_q, chan_product);
    assign rd_fwd  = read_mux(rd_addr, ctrl_d, stage_on_d, clear_style_d, chan_product);
    assign hrdata_d = rd_take ? (fwd_hit ? rd_fwd : rd_word) : hrdata;

    // write data lands in the data phase; unmapped writes are dropped
    assign ctrl_d = (wr_pend_q && wr_addr_q == ADDR_CTRL)
                    ? hwdata[CTRL_W-1:0] : ctrl_q;
    assign stage_on_d = (wr_pend_q && wr_addr_q == ADDR_STAGE_ON)
                        ? hwdata[STAGE_SET_W-1:0] : stage_on_q;
    assign clear_style_d = (wr_pend_q && wr_addr_q == ADDR_CLEAR_STYLE)
                           ? hwdata[STAGE_SET_W-1:0] : clear_style_q;

    // bus-side state; zero wait states so hreadyout stays high
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_pend_q     <= 1'b0;
            wr_addr_q     <= '0;
            hrdata        <= '0;
            hreadyout     <= 1'b1;
            hresp         <= HRESP_OKAY;
            ctrl_q        <= CTRL_RESET;
            stage_on_q    <= STAGE_ON_RESET;
            clear_style_q <= CLEAR_STYLE_RESET;
        end else begin
            wr_pend_q     <= wr_take;
            wr_addr_q     <= wr_take ? rd_addr : wr_addr_q;
            hrdata        <= hrdata_d;
            hreadyout     <= 1'b1;
            hresp         <= HRESP_OKAY;
            ctrl_q        <= ctrl_d;
            stage_on_q    <= stage_on_d;
            clear_style_q <= clear_style_d;
        end
    end

    // ---------------------------------------------------------------
    // four channels
    // ---------------------------------------------------------------
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        // operand x stage; channel reset n reaches only channel n
        qim_stage #(.WIDTH(OPND_W)) u_x_stage (
            .stage_clk   (stage_clk),
            .present     (on_set.operand_x[ch]),
            .clear_async (async_set.operand_x[ch]),
            .clear_low   (chan_clear_low[ch]),
            .capture     (operand_x_stage_hold_n[ch]),
            .d           (multiplicand_x[ch]),
            .q           (x_staged[ch])
        );

        // operand y stage
        qim_stage #(.WIDTH(OPND_W)) u_y_stage (
            .stage_clk   (stage_clk),
            .present     (on_set.operand_y[ch]),
            .clear_async (async_set.operand_y[ch]),
            .clear_low   (chan_clear_low[ch]),
            .capture     (operand_y_stage_hold_n[ch]),
            .d           (multiplicand_y[ch]),
            .q           (y_staged[ch])
        );

        // the multiply itself, one per channel
        qim_mult_unit u_mult (
            .encoding (encoding),
            .x        (x_staged[ch]),
            .y        (y_staged[ch]),
            .product  (raw_product[ch])
        );

        // product stage drives the channel's own 16-bit bus
        qim_stage #(.WIDTH(PROD_W)) u_p_stage (
            .stage_clk   (stage_clk),
            .present     (on_set.product[ch]),
            .clear_async (async_set.product[ch]),
            .clear_low   (chan_clear_low[ch]),
            .capture     (product_stage_hold_n[ch]),
            .d           (raw_product[ch]),
            .q           (chan_product[ch])
        );
    end
endmodule

// [dv/qim_fabric_model.sv]
// fabric-side partner: operands, stage enables and channel clears
`timescale 1ns/100ps
module qim_fabric_model (
    output qim_pkg::qim_quad_opnd_t opx,
    output qim_pkg::qim_quad_opnd_t opy,
    output qim_pkg::qim_chan_bits_t clr,
    output qim_pkg::qim_chan_bits_t hx,
    output qim_pkg::qim_chan_bits_t hy,
    output qim_pkg::qim_chan_bits_t hp
);
    import qim_pkg::*;
    // idle fabric: clears released, every stage enabled, operands zero
    initial begin
        opx = '0;
        opy = '0;
        clr = 4'hf;
        hx  = 4'hf;
        hy  = 4'hf;
        hp  = 4'hf;
    end
    // whole 8-bit operands only; wider work belongs on another block
    task automatic put(input int c, input qim_opnd_t a, input qim_opnd_t b);
        opx[c] <= a;
        opy[c] <= b;
    endtask
    // levels change just after a rising edge, like the rest of the fabric
    task automatic ctl(input qim_chan_bits_t c, input qim_chan_bits_t x,
                       input qim_chan_bits_t y, input qim_chan_bits_t p);
        clr <= c;
        hx  <= x;
        hy  <= y;
        hp  <= p;
    endtask
endmodule

// [dv/qim_quad_mult_props.sv]
// checker: port-level properties of the quad 8x8 multiplier
`timescale 1ns/100ps
module qim_quad_mult_props (
    input wire logic                    clock,
    input wire logic                    resetn,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire qim_pkg::qim_quad_opnd_t multiplicand_x,
    input wire qim_pkg::qim_quad_opnd_t multiplicand_y,
    input wire qim_pkg::qim_chan_bits_t chan_clear_low,
    input wire qim_pkg::qim_chan_bits_t product_stage_hold_n,
    input wire qim_pkg::qim_quad_prod_t chan_product
);
    import qim_pkg::*;
    logic        wr_q;
    logic [7:0]  ad_q;
    logic [2:0]  ctl_q;
    logic [11:0] on_q;
    logic [11:0] sty_q;
    // shadow of the config words, followed from the write data phases
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_q  <= 1'b0;
            ad_q  <= 8'h00;
            ctl_q <= CTRL_RESET;
            on_q  <= STAGE_ON_RESET;
            sty_q <= CLEAR_STYLE_RESET;
        end else if (hready) begin
            wr_q <= hsel && hwrite && htrans == HTRANS_NONSEQ;
            ad_q <= haddr[7:0];
            if (wr_q && ad_q == ADDR_CTRL) ctl_q <= hwdata[2:0];
            if (wr_q && ad_q == ADDR_STAGE_ON) on_q <= hwdata[11:0];
            if (wr_q && ad_q == ADDR_CLEAR_STYLE) sty_q <= hwdata[11:0];
        end
    end
    // reference products, computed apart from the design
    wire         off = on_q == 12'h000;
    wire [1:0]   enc = ctl_q[2:1];
    wire         p0  = !ctl_q[0] && on_q == 12'h100 && enc == 2'h0;
    qim_prod_t   u0, u1, s3;
    logic [13:0] m2;
    assign u0 = multiplicand_x[0] * multiplicand_y[0];
    assign u1 = multiplicand_x[1] * multiplicand_y[1];
    assign s3 = $signed(multiplicand_x[3]) * $signed(multiplicand_y[3]);
    assign m2 = multiplicand_x[2][6:0] * multiplicand_y[2][6:0];
    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    byp_unsigned_a: assert property (off && enc == 2'h0 |-> chan_product[0] == u0)
        else $error("unsigned bypass product wrong");
    byp_twos_a: assert property (off && enc == 2'h1 |-> chan_product[3] == s3)
        else $error("signed bypass product wrong");
    byp_signmag_a: assert property (off && enc == 2'h2 |->
        chan_product[2] == {multiplicand_x[2][7] ^ multiplicand_y[2][7], 1'b0, m2})
        else $error("sign-magnitude product wrong");
    prod_capture_a: assert property (p0 && chan_clear_low[0] && product_stage_hold_n[0]
        |=> chan_product[0] == $past(u0)) else $error("product stage latency wrong");
    prod_hold_a: assert property (!ctl_q[0] && on_q[8] && chan_clear_low[0]
        && !product_stage_hold_n[0] |=> $stable(chan_product[0]))
        else $error("product stage did not hold");
    sync_clear_a: assert property (!ctl_q[0] && on_q[8] && !sty_q[8]
        && !chan_clear_low[0] |=> chan_product[0] == 16'h0000)
        else $error("clocked clear missed");
    async_clear_a: assert property (on_q[8] && sty_q[8] && !chan_clear_low[0]
        |-> chan_product[0] == 16'h0000) else $error("unclocked clear missed");
    off_reset_a: assert property (on_q == 12'h100 && enc == 2'h0 && !chan_clear_low[1]
        |-> chan_product[1] == u1) else $error("clear touched a bypassed stage");
endmodule
bind qim_quad_mult qim_quad_mult_props props (.clock(clock), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .multiplicand_x(multiplicand_x), .multiplicand_y(multiplicand_y),
    .chan_clear_low(chan_clear_low), .product_stage_hold_n(product_stage_hold_n),
    .chan_product(chan_product));

// [dv/tb_qim_quad_mult.sv]
// self-checking testbench of the quad 8x8 multiplier
`timescale 1ns/100ps
module tb_qim_quad_mult;
    import qim_pkg::*;
    logic           clock = 1'b0;
    logic           resetn = 1'b0;
    logic           hsel = 1'b0;
    logic           hwrite = 1'b0;
    logic [1:0]     htrans = 2'h0;
    logic [31:0]    haddr = 32'h0;
    logic [31:0]    hwdata = 32'h0;
    logic           hreadyout, hresp;
    logic [31:0]    hrdata;
    qim_quad_opnd_t opx, opy;
    qim_chan_bits_t clr, hx, hy, hp;
    qim_quad_prod_t prod;
    int             err_count = 0;
    int             checks_done = 0;
    int             cyc = 0;
    qim_fabric_model fm (.opx(opx), .opy(opy), .clr(clr), .hx(hx), .hy(hy), .hp(hp));
    qim_quad_mult dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .multiplicand_x(opx), .multiplicand_y(opy), .chan_clear_low(clr),
        .operand_x_stage_hold_n(hx), .operand_y_stage_hold_n(hy),
        .product_stage_hold_n(hp), .chan_product(prod));
    // -----------------------------------------------------------------
    // clock, timeout and shared tasks
    // -----------------------------------------------------------------
    always #10 clock = ~clock;
    // a hang would stall the run forever, so cut it after a generous ceiling
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one single ahb-lite word transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        tick(1);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do tick(1); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do tick(1); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    function automatic qim_prod_t mul(input logic [1:0] e, input qim_opnd_t a, b);
        logic [13:0] m;
        m = a[6:0] * b[6:0];
        if (e == 2'h1) return $signed(a) * $signed(b);
        if (e == 2'h2) return {a[7] ^ b[7], 1'b0, m};
        return a * b;
    endfunction
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] q;
        bus(1'b0, ADDR_CTRL, 32'h0, q);
        chk(q, 32'(CTRL_RESET));
        chk(32'(hresp), 32'(HRESP_OKAY));
        bus(1'b0, ADDR_STAGE_ON, 32'h0, q);
        chk(q, 32'(STAGE_ON_RESET));
        bus(1'b0, ADDR_CLEAR_STYLE, 32'h0, q);
        chk(q, 32'(CLEAR_STYLE_RESET));
        bus(1'b1, ADDR_STAGE_ON, 32'hffff_ffff, q);
        bus(1'b0, ADDR_STAGE_ON, 32'h0, q);
        chk(q, 32'h0000_0fff);
        bus(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
    endtask
    // every encoding on all four channels, stages bypassed; the spare code acts as unsigned
    task automatic t_bypass();
        logic [31:0] q;
        qim_opnd_t   av[3] = '{8'hff, 8'h80, 8'h83};
        qim_opnd_t   bv[3] = '{8'hff, 8'h7f, 8'h00};
        bus(1'b1, ADDR_STAGE_ON, 32'h0, q);
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, ADDR_CTRL, 32'(e * 2), q);
            for (int v = 0; v < 3; v++) begin
                tick(1);
                for (int c = 0; c < 4; c++) fm.put(c, av[v] ^ 8'(c), bv[v] + 8'(c));
                #1;
                for (int c = 0; c < 4; c++)
                    chk(prod[c], mul(2'(e), av[v] ^ 8'(c), bv[v] + 8'(c)));
            end
            // operands stand, so the read-back word must carry channels 3 and 2
            bus(1'b0, ADDR_PRODUCT_HI, 32'h0, q);
            chk(q, {mul(2'(e), 8'h80, 8'h03), mul(2'(e), 8'h81, 8'h02)});
        end
    endtask
    // three stages, two deep (x and y in parallel, then product), give two cycles; disabled enables hold their stage
    task automatic t_latency();
        logic [31:0] q;
        bus(1'b1, ADDR_CTRL, 32'h0, q);
        bus(1'b1, ADDR_STAGE_ON, 32'h111, q);
        tick(1);
        fm.put(0, 8'h11, 8'h02);
        tick(1);
        fm.put(0, 8'h05, 8'h07);
        tick(1);
        #1 chk(prod[0], 32'h22);
        tick(1);
        fm.ctl(4'hf, 4'he, 4'hf, 4'hf);
        fm.put(0, 8'h09, 8'h09);
        tick(2);
        #1 chk(prod[0], 32'h2d);
        tick(1);
        fm.ctl(4'hf, 4'hf, 4'hf, 4'he);
        fm.put(0, 8'h01, 8'h01);
        tick(3);
        #1 chk(prod[0], 32'h2d);
        tick(1);
        fm.ctl(4'hf, 4'hf, 4'hf, 4'hf);
    endtask
    // clocked clear waits for an edge, unclocked acts at once, one channel only
    task automatic t_clear();
        logic [31:0] q;
        bus(1'b1, ADDR_STAGE_ON, 32'h333, q);
        tick(1);
        fm.put(0, 8'h03, 8'h03);
        fm.put(1, 8'h04, 8'h04);
        tick(3);
        fm.ctl(4'he, 4'hf, 4'hf, 4'hf);
        #1 chk(prod[0], 32'h9);
        tick(1);
        #1 chk(prod[0], 32'h0);
        chk(prod[1], 32'h10);
        tick(1);
        fm.ctl(4'hf, 4'hf, 4'hf, 4'hf);
        bus(1'b1, ADDR_CLEAR_STYLE, 32'h333, q);
        tick(1);
        fm.ctl(4'he, 4'hf, 4'hf, 4'hf);
        #1 chk(prod[0], 32'h0);
        tick(1);
        fm.ctl(4'hf, 4'hf, 4'hf, 4'hf);
        bus(1'b1, ADDR_CLEAR_STYLE, 32'h0, q);
    endtask
    // falling-edge mode: the product stage moves half a cycle after the inputs
    task automatic t_fall();
        logic [31:0] q;
        bus(1'b1, ADDR_STAGE_ON, 32'h100, q);
        tick(1);
        fm.put(0, 8'h02, 8'h02);
        tick(1);
        #1 chk(prod[0], 32'h4);
        bus(1'b1, ADDR_CTRL, 32'h1, q);
        tick(1);
        fm.put(0, 8'h10, 8'h03);
        fm.ctl(4'hd, 4'hf, 4'hf, 4'hf);
        #1 chk(prod[0], 32'h4);
        chk(prod[1], 32'h10);
        @(negedge clock);
        #1 chk(prod[0], 32'h30);
        tick(1);
        fm.ctl(4'hf, 4'hf, 4'hf, 4'hf);
        bus(1'b1, ADDR_CTRL, 32'h0, q);
    endtask
    // reset held ten cycles, then the scenarios in turn
    initial begin
        tick(10);
        resetn <= 1'b1;
        t_regs();
        t_bypass();
        t_latency();
        t_clear();
        t_fall();
        complete_run();
    end
endmodule
